// File: eda_access_unit.sv
// Data EEPROM access unit: registers, unlock, write sequencer, resets.
// Assumes a CPU on the plain register port and one core clock.
// What this block does
// - Byte data register and address register.
// - 256 or 128 bytes; small hides address bit 7.
// - Byte write erases then programs automatically.
// - Internal timer times each write.
// - Protection zeroes programmer reads, CPU unaffected.
// - Control implements four low bits only.
// - Start bits set-only; hardware clears them.
// - Writes need write-allow; clear at power-up.
// - Reset during write sets abort flag.
// - Aborting reset clears data and address.
// - Write completion sets sticky done flag.
// - Unlock register reads all zeros.
// - Read start loads data in one cycle.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module eda_access_unit #(
    parameter int unsigned WRITE_CYCLES = eda_pkg::WRITE_CYCLES,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic master_clear_pin,
    input wire logic watchdog_reset,
    input wire logic brownout_reset,
    input wire logic code_protect,
    input wire logic prog_rd,
    input wire logic [7:0] prog_addr,
    output logic [7:0] prog_rdata,
    output logic write_done_flag,
    output logic write_busy
);
    import eda_pkg::*;

    // Address mask for the built variant.
    localparam logic [7:0] ADDR_MASK = LARGE_VARIANT ? ADDR_MASK_LARGE : ADDR_MASK_SMALL;

    // Pin synchroniser for the master clear input.
    logic master_clear_pin_meta_reg;
    logic master_clear_pin_sync_reg;
    // Combined warm reset from pin, watchdog and brown-out.
    logic warm_reset;
    // Software-visible registers.
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    logic rd_bit_reg;
    logic wr_bit_reg;
    logic allow_reg;
    logic abort_reg;
    logic done_flag_reg;
    // Unlock progress and write sequencer.
    eda_key_t key_reg;
    eda_wstate_t wstate_reg;
    eda_wstate_t wstate_next;
    // Byte and address captured at write start.
    logic [7:0] lat_addr_reg;
    logic [7:0] lat_data_reg;
    // Bus read data and programmer read data.
    logic [7:0] rdata_reg;
    logic [7:0] prog_rdata_reg;
    // Array and timer wiring.
    logic [7:0] arr_rdata;
    logic [7:0] arr_pdata;
    logic timer_done;
    logic wr_start;
    logic ctrl_wr;
    logic write_busy_int;

    // The pin is asynchronous, so two flops come before any use.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_clear_pin_meta_reg <= 1'b0;
            master_clear_pin_sync_reg <= 1'b0;
        end
        else
        begin
            master_clear_pin_meta_reg <= master_clear_pin;
            master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
        end
    end

    // Watchdog and brown-out come from on-chip logic on this clock.
    assign warm_reset = master_clear_pin_sync_reg | watchdog_reset | brownout_reset;
    assign ctrl_wr = bus_wr && (bus_addr == REG_CTRL) && !warm_reset;
    assign write_busy_int = (wstate_reg != W_IDLE);

    // A write starts only on the bus write that follows both keys.
    assign wr_start = ctrl_wr && bus_wdata[CTRL_WR_BIT] && allow_reg
        && (key_reg == KEY_ARMED) && !write_busy_int;

    // Unlock tracker: any unrelated write drops the sequence.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_reg <= KEY_IDLE;
        end
        else if (warm_reset)
        begin
            key_reg <= KEY_IDLE;
        end
        else if (bus_wr)
        begin
            if (bus_addr == REG_UNLOCK && bus_wdata == KEY_FIRST)
            begin
                key_reg <= KEY_ONE;
            end
            else if (key_reg == KEY_ONE && bus_addr == REG_UNLOCK
                && bus_wdata == KEY_SECOND)
            begin
                key_reg <= KEY_ARMED;
            end
            else
            begin
                key_reg <= KEY_IDLE;
            end
        end
    end

    // Write sequencer: one erase cycle, then the timed program phase.
    always_comb
    begin
        wstate_next = wstate_reg;
        unique case (wstate_reg)
            W_IDLE:
            begin
                if (wr_start)
                begin
                    wstate_next = W_ERASE;
                end
            end
            W_ERASE:
            begin
                wstate_next = W_PROG;
            end
            W_PROG:
            begin
                if (timer_done)
                begin
                    wstate_next = W_IDLE;
                end
            end
            default:
            begin
                wstate_next = W_IDLE;
            end
        endcase
    end

    // Warm reset abandons the write at once.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wstate_reg <= W_IDLE;
        end
        else if (warm_reset)
        begin
            wstate_reg <= W_IDLE;
        end
        else
        begin
            wstate_reg <= wstate_next;
        end
    end

    // Capture the target so a careless register change cannot corrupt it.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lat_addr_reg <= ADDR_RESET;
            lat_data_reg <= DATA_RESET;
        end
        else if (wr_start)
        begin
            lat_addr_reg <= addr_reg;
            lat_data_reg <= data_reg;
        end
    end

    // Control bits; set-only start bits, set wins over hardware clear.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_bit_reg <= 1'b0;
            wr_bit_reg <= 1'b0;
            allow_reg <= 1'b0;
            abort_reg <= 1'b0;
        end
        else if (warm_reset)
        begin
            rd_bit_reg <= 1'b0;
            wr_bit_reg <= 1'b0;
            allow_reg <= 1'b0;
            if (write_busy_int)
            begin
                abort_reg <= 1'b1;
            end
        end
        else
        begin
            if (ctrl_wr && bus_wdata[CTRL_RD_BIT])
            begin
                rd_bit_reg <= 1'b1;
            end
            else if (rd_bit_reg)
            begin
                rd_bit_reg <= 1'b0;
            end
            if (wr_start)
            begin
                wr_bit_reg <= 1'b1;
            end
            else if (timer_done)
            begin
                wr_bit_reg <= 1'b0;
            end
            if (ctrl_wr)
            begin
                allow_reg <= bus_wdata[CTRL_ALLOW_BIT];
            end
            if (timer_done)
            begin
                abort_reg <= 1'b0;
            end
            else if (ctrl_wr)
            begin
                abort_reg <= bus_wdata[CTRL_ABORT_BIT];
            end
        end
    end

    // Data and address registers; a read completion loads the data.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_reg <= DATA_RESET;
            addr_reg <= ADDR_RESET;
        end
        else if (warm_reset)
        begin
            if (write_busy_int)
            begin
                data_reg <= DATA_RESET;
                addr_reg <= ADDR_RESET;
            end
        end
        else
        begin
            if (rd_bit_reg)
            begin
                data_reg <= arr_rdata;
            end
            else if (bus_wr && bus_addr == REG_DATA)
            begin
                data_reg <= bus_wdata;
            end
            if (bus_wr && bus_addr == REG_ADDR)
            begin
                addr_reg <= bus_wdata & ADDR_MASK;
            end
        end
    end

    // Completion flag; hardware set wins over a software clear.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_flag_reg <= 1'b0;
        end
        else if (timer_done && !warm_reset)
        begin
            done_flag_reg <= 1'b1;
        end
        else if (bus_wr && bus_addr == REG_FLAGS && !warm_reset)
        begin
            done_flag_reg <= bus_wdata[FLAG_DONE_BIT];
        end
    end

    // Bus read data stand only in the cycle after the strobe.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 8'h00;
        end
        else if (!bus_rd)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            case (bus_addr)
                REG_DATA: rdata_reg <= data_reg;
                REG_ADDR: rdata_reg <= addr_reg;
                REG_CTRL: rdata_reg <= {4'h0, abort_reg, allow_reg, wr_bit_reg, rd_bit_reg};
                REG_FLAGS: rdata_reg <= {done_flag_reg, 7'h00};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // Programmer port; protection blanks the array to that port only.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_rdata_reg <= 8'h00;
        end
        else if (prog_rd && !code_protect)
        begin
            prog_rdata_reg <= arr_pdata;
        end
        else
        begin
            prog_rdata_reg <= 8'h00;
        end
    end

    // The timer stops on warm reset so an aborted write never completes.
    eda_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(wstate_reg == W_ERASE),
        .stop(warm_reset),
        .done(timer_done)
    );

    eda_array u_array (
        .core_clk(core_clk),
        .erase(wstate_reg == W_ERASE),
        .program_pulse(timer_done && wstate_reg == W_PROG && !warm_reset),
        .waddr(lat_addr_reg),
        .wdata(lat_data_reg),
        .raddr(addr_reg),
        .paddr(prog_addr & ADDR_MASK),
        .rdata(arr_rdata),
        .pdata(arr_pdata)
    );

    assign bus_rdata = rdata_reg;
    assign prog_rdata = prog_rdata_reg;
    assign write_done_flag = done_flag_reg;
    assign write_busy = wr_bit_reg;

    // Checks beside the logic they guard.
    rd_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_bit_reg && !warm_reset |=> !rd_bit_reg && data_reg == $past(arr_rdata))
        else $error("read start did not load data in one cycle");
    ctrl_upper_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rd && bus_addr == REG_CTRL |=> bus_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    unlock_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rd && bus_addr == REG_UNLOCK |=> bus_rdata == 8'h00)
        else $error("unlock register read not zero");
    start_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(wr_bit_reg) |-> $past(allow_reg) && $past(key_reg) == KEY_ARMED)
        else $error("write began without allow and keys");
    wr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_bit_reg && !timer_done && !warm_reset |=> wr_bit_reg)
        else $error("write start bit dropped early");
    done_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_done && !warm_reset |=> done_flag_reg && !wr_bit_reg && !abort_reg)
        else $error("completion did not set done flag");
    abort_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        warm_reset && write_busy_int |=> abort_reg && data_reg == 8'h00 && addr_reg == 8'h00)
        else $error("aborted write not flagged and cleared");
    protect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        prog_rd && code_protect |=> prog_rdata == 8'h00)
        else $error("protected array visible to programmer");
    erase_then_prog_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wstate_reg == W_ERASE && !warm_reset |=> wstate_reg == W_PROG && !timer_done)
        else $error("erase not followed by timed program phase");
    small_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !LARGE_VARIANT |-> addr_reg[7] == 1'b0)
        else $error("address bit 7 set on small array");

    read_c: cover property (@(posedge core_clk) disable iff (!rst_n) rd_bit_reg);
    write_c: cover property (@(posedge core_clk) disable iff (!rst_n) timer_done);
    abort_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        warm_reset && write_busy_int);

endmodule

// File: eda_pkg.sv
// Constants and types shared by the data EEPROM access unit.
// Assumes a single 100 MHz core clock and byte-wide register access.
package eda_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_CTRL = 3'h2;
    localparam logic [2:0] REG_UNLOCK = 3'h3;
    localparam logic [2:0] REG_FLAGS = 3'h4;

    // Field positions in the control register.
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_ALLOW_BIT = 2;
    localparam int CTRL_ABORT_BIT = 3;

    // Write-done position in the peripheral flag register.
    localparam int FLAG_DONE_BIT = 7;

    // Values after reset.
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;

    // Address masks for the two array sizes.
    localparam logic [7:0] ADDR_MASK_LARGE = 8'hff;
    localparam logic [7:0] ADDR_MASK_SMALL = 8'h7f;
    localparam int ARRAY_BYTES = 256;

    // Unlock key pair; the values are an implementation choice.
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Value an erased cell holds before it is programmed.
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Self-timed write duration and its cycle count.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WRITE_TIME_NS = 5000000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    // Unlock sequence progress.
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_ONE = 2'b01,
        KEY_ARMED = 2'b10
    } eda_key_t;

    // Write sequencer states.
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_ERASE = 2'b01,
        W_PROG = 2'b10
    } eda_wstate_t;

endpackage

// File: eda_write_timer.sv
// Self-timed write duration counter for the data EEPROM.
// Assumes start and stop come from logic on the same core clock.
`timescale 1ns/1ps
module eda_write_timer #(
    parameter int unsigned CYCLES = eda_pkg::WRITE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic stop,
    output logic done
);
    import eda_pkg::*;

    // Remaining cycles and a running flag.
    logic [TIMER_W-1:0] cnt_reg;
    logic running_reg;
    logic done_reg;

    // Count down from the loaded figure; stop wins over everything.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            running_reg <= 1'b0;
        end
        else if (stop)
        begin
            running_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= TIMER_W'(CYCLES - 1);
            running_reg <= 1'b1;
        end
        else if (running_reg)
        begin
            if (cnt_reg == '0)
            begin
                running_reg <= 1'b0;
            end
            else
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // One-cycle completion pulse after the last counted cycle.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= running_reg && (cnt_reg == '0) && !stop && !start;
        end
    end

    assign done = done_reg;

endmodule

// File: eda_array.sv
// Byte array of the data EEPROM with a CPU port and a programmer port.
// Assumes erase and program pulses come from the write sequencer.
`timescale 1ns/1ps
module eda_array (
    input wire logic core_clk,
    input wire logic erase,
    input wire logic program_pulse,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] raddr,
    input wire logic [7:0] paddr,
    output logic [7:0] rdata,
    output logic [7:0] pdata
);
    import eda_pkg::*;

    // Nonvolatile contents; no reset, as stored data survives resets.
    logic [7:0] mem [0:ARRAY_BYTES-1];

    // Erase sets the cell to the blank value, program stores the byte.
    always_ff @(posedge core_clk)
    begin
        if (erase)
        begin
            mem[waddr] <= ERASED_BYTE;
        end
        else if (program_pulse)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Both read ports are combinational; the callers register them.
    assign rdata = mem[raddr];
    assign pdata = mem[paddr];

endmodule

// File: eda_cpu_model.sv
// Behavioural model of the CPU core that reaches the access unit's registers.
// Assumes one shared core clock and a register port that never makes the master wait.
`timescale 1ns/1ps
module eda_cpu_model (
    input wire logic core_clk,
    output logic [2:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [7:0] bus_rdata
);
    import eda_pkg::*;

    // The port idles with both strobes low from time zero.
    initial
    begin
        bus_addr = 3'h7;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // One write cycle; the data lines are scrambled after release so a design
    // that samples them late cannot pass by luck.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
    endtask

    // One read cycle; the answer stands only in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    // The key pair goes straight before the control write, with nothing between.
    task automatic start_write(input logic [7:0] ctrl);
        wr(REG_UNLOCK, KEY_FIRST);
        wr(REG_UNLOCK, KEY_SECOND);
        wr(REG_CTRL, ctrl);
    endtask
endmodule

// File: testbench.sv
// Self-checking bench for the data EEPROM access unit.
// Assumes the CPU model drives the register port; the bench drives everything else.
`timescale 1ns/1ps
module testbench;
    import eda_pkg::*;

    // A short write time keeps the run brief; all expectations derive from it.
    localparam int WC = 8;
    logic core_clk, rst_n, master_clear_pin, watchdog_reset, brownout_reset;
    logic code_protect, prog_rd, bus_wr, bus_rd, write_done_flag, write_busy;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, prog_addr, prog_rdata, v;
    // Read data of the small-array instance, which shares every input.
    logic [7:0] small_rdata;
    int fails, check_count, n;

    eda_access_unit #(.WRITE_CYCLES(WC), .LARGE_VARIANT(1'b1)) eda_access_unit_inst (
        .core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .master_clear_pin(master_clear_pin), .watchdog_reset(watchdog_reset),
        .brownout_reset(brownout_reset), .code_protect(code_protect), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata),
        .write_done_flag(write_done_flag), .write_busy(write_busy));

    eda_cpu_model eda_cpu_model_inst (
        .core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    // The small variant sees the same traffic, so its address masking can be judged.
    eda_access_unit #(.WRITE_CYCLES(WC), .LARGE_VARIANT(1'b0)) eda_access_unit_small_inst (
        .core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(small_rdata),
        .master_clear_pin(master_clear_pin), .watchdog_reset(watchdog_reset),
        .brownout_reset(brownout_reset), .code_protect(code_protect), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_rdata(),
        .write_done_flag(), .write_busy());

    // Free-running 100 MHz core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic results();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Byte comparison with case equality so an unknown never matches.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read through the CPU model, judged against a worked-out value.
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        eda_cpu_model_inst.rd(a, v);
        chk(v, exp);
    endtask

    // Waits for write_busy to reach a level; a spent bound ends the run as a failure.
    task automatic wait_busy(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (write_busy !== lvl)
        begin
            @(posedge core_clk);
            #1;
            cnt++;
            if (cnt > lim)
            begin
                fails++;
                $display("[FAIL] t=%0t busy=%h exp=%h", $time, write_busy, lvl);
                results();
            end
        end
    endtask

    // Drives one of the three warm reset sources.
    task automatic warm(input int src, input logic lvl);
        case (src)
            0: master_clear_pin <= lvl;
            1: watchdog_reset <= lvl;
            default: brownout_reset <= lvl;
        endcase
    endtask

    // Every index reads zero after power-on, unmapped and unlock ones included.
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
            rdchk(3'(i), 8'h00);
        eda_cpu_model_inst.wr(REG_CTRL, 8'hf4);
        rdchk(REG_CTRL, 8'h04);
        eda_cpu_model_inst.wr(REG_UNLOCK, KEY_FIRST);
        rdchk(REG_UNLOCK, 8'h00);
        eda_cpu_model_inst.wr(REG_ADDR, 8'hff);
        rdchk(REG_ADDR, 8'hff);
        chk(small_rdata, 8'h7f);
        $display("test reset done");
    endtask

    // Starts that must be refused: no allow, no keys, keys broken by another write.
    task automatic t_refuse();
        eda_cpu_model_inst.wr(REG_CTRL, 8'h00);
        eda_cpu_model_inst.start_write(8'h02);
        #1;
        chk({7'h00, write_busy}, 8'h00);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h04);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h06);
        #1;
        chk({7'h00, write_busy}, 8'h00);
        eda_cpu_model_inst.wr(REG_UNLOCK, KEY_FIRST);
        eda_cpu_model_inst.wr(REG_UNLOCK, KEY_SECOND);
        eda_cpu_model_inst.wr(REG_DATA, 8'h11);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h06);
        #1;
        chk({7'h00, write_busy}, 8'h00);
        rdchk(REG_CTRL, 8'h04);
        $display("test refuse done");
    endtask

    // A full timed write, then a read back of the same byte.
    task automatic t_write(input logic [7:0] a, input logic [7:0] d);
        eda_cpu_model_inst.wr(REG_FLAGS, 8'h00);
        eda_cpu_model_inst.wr(REG_DATA, d);
        eda_cpu_model_inst.wr(REG_ADDR, a);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h04);
        eda_cpu_model_inst.start_write(8'h06);
        #1;
        chk({7'h00, write_busy}, 8'h01);
        rdchk(REG_CTRL, 8'h06);
        // Software leaves the registers alone until the write is over.
        wait_busy(1'b0, WC + 8, n);
        chk({7'h00, (n >= WC - 3) && (n <= WC + 3)}, 8'h01);
        chk({7'h00, write_done_flag}, 8'h01);
        rdchk(REG_FLAGS, 8'h80);
        rdchk(REG_CTRL, 8'h04);
        eda_cpu_model_inst.wr(REG_DATA, 8'h00);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h05);
        rdchk(REG_CTRL, 8'h04);
        rdchk(REG_DATA, d);
        rdchk(REG_ADDR, a);
        eda_cpu_model_inst.wr(REG_FLAGS, 8'h00);
        rdchk(REG_FLAGS, 8'h00);
        $display("test write %h done", a);
    endtask

    // Reads one byte through the programmer port.
    task automatic prog(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        prog_rd <= 1'b1;
        prog_addr <= a;
        @(posedge core_clk);
        prog_rd <= 1'b0;
        prog_addr <= ~a;
        #1;
        chk(prog_rdata, exp);
    endtask

    // Protection hides the array from the programmer but not from the CPU.
    task automatic t_prog();
        prog(8'h81, 8'hc3);
        prog(8'h01, 8'h5a);
        @(posedge core_clk);
        code_protect <= 1'b1;
        prog(8'h81, 8'h00);
        eda_cpu_model_inst.wr(REG_ADDR, 8'h01);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h01);
        rdchk(REG_DATA, 8'h5a);
        @(posedge core_clk);
        code_protect <= 1'b0;
        $display("test protect done");
    endtask

    // A warm reset in mid-write must flag the abort and clear data and address.
    task automatic t_abort(input int src);
        eda_cpu_model_inst.wr(REG_DATA, 8'h77);
        eda_cpu_model_inst.wr(REG_ADDR, 8'h20);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h04);
        eda_cpu_model_inst.start_write(8'h06);
        repeat (3) @(posedge core_clk);
        warm(src, 1'b1);
        repeat (4) @(posedge core_clk);
        warm(src, 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        chk({7'h00, write_busy}, 8'h00);
        chk({7'h00, write_done_flag}, 8'h00);
        rdchk(REG_CTRL, 8'h08);
        rdchk(REG_DATA, 8'h00);
        rdchk(REG_ADDR, 8'h00);
        eda_cpu_model_inst.wr(REG_CTRL, 8'h00);
        rdchk(REG_CTRL, 8'h00);
        $display("test abort %0d done", src);
    endtask

    // Main sequence: power-on reset, then the scenarios in turn.
    initial
    begin
        fails = 0;
        check_count = 0;
        rst_n = 1'b0;
        master_clear_pin = 1'b0;
        watchdog_reset = 1'b0;
        brownout_reset = 1'b0;
        code_protect = 1'b0;
        prog_rd = 1'b0;
        prog_addr = 8'h00;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_refuse();
        t_write(8'h81, 8'h3c);
        t_write(8'h01, 8'h5a);
        // Overwriting checks a changed byte: the array's program stores the whole byte, so it could raise bits without the erase.
        t_write(8'h81, 8'hc3);
        t_prog();
        for (int s = 0; s < 3; s++)
            t_abort(s);
        results();
    end
endmodule
